// ---- logic/pds_paging.v ----
`include "pds_paging_regs.vh"
`default_nettype none

// Operation
// - Separate read and write page registers; reads use read page, writes write page.
// - Read page may hold a program-space page while write page holds a data page.
// - A boundary-crossing indirect calculation first clears address bit 15.
// - Page crossing only for paged start address and pre/post-modified indirect mode.
// - Overflow increments the active page and sets address bit 15.
// - Underflow decrements the active page and sets address bit 15.
// - Offset, modulo, bit-reversed crossings set bit 15, page unchanged, wrapping.
// - Read overflow at 0x1FF/0x3FF, write at 0x1FF: page kept, bit 15 cleared.
// - Underflow at 0x001, read underflow at 0x200: page kept, bit 15 cleared; 0x300 goes 0x2FF.
// - Nonzero pages reached only through upper half, bit 15 set, plus page register.
// - Both page registers reset to page one.
// - Paged access with a zero page register raises an address error trap.
// - Paged write through a program-space write page raises an address error trap.
module pds_paging (
  input wire ref_clk,
  input wire rst,
  input wire rd_page_load,
  input wire wr_page_load,
  input wire [`PDS_PAGE_W-1:0] page_load_data,
  input wire acc_valid,
  input wire acc_write,
  input wire [`PDS_MODE_W-1:0] acc_mode,
  input wire [`PDS_EA_W-1:0] base_ea,
  input wire [`PDS_EA_W-1:0] calc_ea,
  input wire calc_ovf,
  input wire calc_unf,
  output wire out_valid,
  output wire [`PDS_EA_W-1:0] effective_address,
  output wire [`PDS_PAGE_W-1:0] out_page,
  output wire [`PDS_EXT_W-1:0] out_ext_addr,
  output wire out_prog_space,
  output wire addr_err_trap,
  output wire [`PDS_PAGE_W-1:0] read_page_reg,
  output wire [`PDS_PAGE_W-1:0] write_page_reg
);

  // Program-space window pages sit in the upper half of the page range
  function is_prog_page;
    input [`PDS_PAGE_W-1:0] page;
    begin
      is_prog_page = page[`PDS_PAGE_PS_BIT];
    end
  endfunction

  reg [`PDS_PAGE_W-1:0] read_page_reg_q;
  reg [`PDS_PAGE_W-1:0] read_page_reg_d;
  reg [`PDS_PAGE_W-1:0] write_page_reg_q;
  reg [`PDS_PAGE_W-1:0] write_page_reg_d;
  reg [`PDS_PAGE_W-1:0] act_page;
  reg [`PDS_PAGE_W-1:0] new_page;
  reg [`PDS_EA_W-1:0] ea_d;
  reg paged;
  reg linear_mode;
  reg wrap_mode;
  reg crossing;
  reg err_d;
  reg ovf_stop;
  reg unf_stop;
  reg page_change;
  // Answer registers; the ports only copy them
  reg out_valid_q;
  reg [`PDS_EA_W-1:0] effective_address_q;
  reg [`PDS_PAGE_W-1:0] out_page_q;
  reg [`PDS_EXT_W-1:0] out_ext_addr_q;
  reg out_prog_space_q;
  reg addr_err_trap_q;

  assign read_page_reg = read_page_reg_q;
  assign write_page_reg = write_page_reg_q;
  assign out_valid = out_valid_q;
  assign effective_address = effective_address_q;
  assign out_page = out_page_q;
  assign out_ext_addr = out_ext_addr_q;
  assign out_prog_space = out_prog_space_q;
  assign addr_err_trap = addr_err_trap_q;

  always @*
  begin
    // active page chosen by access direction
    act_page = acc_write ? write_page_reg_q : read_page_reg_q;
    // only upper half of base space is paged
    paged = base_ea[`PDS_EA_PAGED_BIT];
    linear_mode = (acc_mode == `PDS_MODE_PREMOD) || (acc_mode == `PDS_MODE_POSTMOD);
    wrap_mode = (acc_mode == `PDS_MODE_REGOFS) || (acc_mode == `PDS_MODE_MODULO) ||
      (acc_mode == `PDS_MODE_BITREV);
    // crossing needs paged start and an indirect modifying mode
    crossing = paged && (calc_ovf || calc_unf) && (linear_mode || wrap_mode);
    // page zero is never reachable through the paged window
    // program space is read-only through the window
    err_d = paged && ((act_page == `PDS_PAGE_ZERO) ||
      (acc_write && is_prog_page(write_page_reg_q)));
    // Stop pages fall back to base space, no trap raised
    // overflow stops at the top of the data range, and for reads of the program-space range
    ovf_stop = (act_page == `PDS_PAGE_EDS_LAST) ||
      (!acc_write && (act_page == `PDS_PAGE_PS_MSW_LAST));
    // underflow stops at the bottom of the data range, and for reads of the program-space range
    unf_stop = (act_page == `PDS_PAGE_FIRST) ||
      (!acc_write && (act_page == `PDS_PAGE_PS_LSW_FIRST));
    new_page = act_page;
    page_change = 1'b0;
    ea_d = calc_ea;
    if (crossing)
    begin
      // raw result leaves the window before correction
      ea_d[`PDS_EA_PAGED_BIT] = 1'b0;
      if (wrap_mode)
      begin
        ea_d[`PDS_EA_PAGED_BIT] = 1'b1;
      end
      // Overflow wins when both flags are high
      else if (calc_ovf)
      begin
        if (!ovf_stop)
        begin
          // step to the next page, 0x2FF moves on to 0x300
          new_page = act_page + `PDS_PAGE_FIRST;
          page_change = 1'b1;
          ea_d[`PDS_EA_PAGED_BIT] = 1'b1;
        end
      end
      else if (!unf_stop)
      begin
        // step to the previous page, 0x300 moves back to 0x2FF
        new_page = act_page - `PDS_PAGE_FIRST;
        page_change = 1'b1;
        ea_d[`PDS_EA_PAGED_BIT] = 1'b1;
      end
    end
  end

  always @*
  begin
    read_page_reg_d = read_page_reg_q;
    write_page_reg_d = write_page_reg_q;
    // A trapped access leaves both pages alone
    // only the active page register follows a crossing
    if (acc_valid && !err_d && page_change)
    begin
      if (acc_write)
      begin
        write_page_reg_d = new_page;
      end
      else
      begin
        read_page_reg_d = new_page;
      end
    end
    // Software load wins over a crossing; loading zero is ignored
    // each register loads any nonzero page independently
    if (rd_page_load && (page_load_data != `PDS_PAGE_ZERO))
    begin
      read_page_reg_d = page_load_data;
    end
    if (wr_page_load && (page_load_data != `PDS_PAGE_ZERO))
    begin
      write_page_reg_d = page_load_data;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // both pages start at page one
      read_page_reg_q <= `PDS_PAGE_RESET;
      write_page_reg_q <= `PDS_PAGE_RESET;
    end
    else
    begin
      read_page_reg_q <= read_page_reg_d;
      write_page_reg_q <= write_page_reg_d;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid_q <= 1'b0;
      effective_address_q <= `PDS_EA_RESET;
      out_page_q <= `PDS_PAGE_ZERO;
      out_ext_addr_q <= `PDS_EXT_RESET;
      out_prog_space_q <= 1'b0;
      addr_err_trap_q <= 1'b0;
    end
    else
    begin
      out_valid_q <= acc_valid;
      // trap pulses for one cycle with the answer
      addr_err_trap_q <= acc_valid && err_d;
      // Data outputs hold until the next access
      if (acc_valid)
      begin
        effective_address_q <= ea_d;
        // lower half always maps to page zero
        if (ea_d[`PDS_EA_PAGED_BIT])
        begin
          out_page_q <= new_page;
          out_ext_addr_q <= {new_page, ea_d[`PDS_EA_PAGED_BIT-1:0]};
          out_prog_space_q <= is_prog_page(new_page);
        end
        else
        begin
          out_page_q <= `PDS_PAGE_ZERO;
          out_ext_addr_q <= {`PDS_PAGE_ZERO, ea_d[`PDS_EA_PAGED_BIT-1:0]};
          out_prog_space_q <= 1'b0;
        end
      end
    end
  end

endmodule // pds_paging

`default_nettype wire

// ---- logic/pds_paging_regs.vh ----
`ifndef PDS_PAGING_REGS_VH
`define PDS_PAGING_REGS_VH

// Widths
`define PDS_PAGE_W 10
`define PDS_EA_W 16
`define PDS_EXT_W 25
`define PDS_MODE_W 3

// Page register reset value and special pages
`define PDS_PAGE_RESET 10'h001
`define PDS_PAGE_ZERO 10'h000
`define PDS_PAGE_FIRST 10'h001
`define PDS_PAGE_EDS_LAST 10'h1FF
`define PDS_PAGE_PS_LSW_FIRST 10'h200
`define PDS_PAGE_PS_LSW_LAST 10'h2FF
`define PDS_PAGE_PS_MSW_FIRST 10'h300
`define PDS_PAGE_PS_MSW_LAST 10'h3FF

// Answer register reset values
`define PDS_EA_RESET 16'h0000
`define PDS_EXT_RESET 25'h000_0000

// Field positions
`define PDS_EA_PAGED_BIT 15
`define PDS_PAGE_PS_BIT 9

// Addressing modes of the current access
`define PDS_MODE_PLAIN 3'h0
`define PDS_MODE_PREMOD 3'h1
`define PDS_MODE_POSTMOD 3'h2
`define PDS_MODE_REGOFS 3'h3
`define PDS_MODE_MODULO 3'h4
`define PDS_MODE_BITREV 3'h5

`endif

// ---- tb/pds_agu_model.sv ----
`default_nettype none
module pds_agu_model (
  input wire logic [15:0] base_ea,
  input wire logic [15:0] step,
  input wire logic dec,
  output logic [15:0] calc_ea,
  output logic calc_ovf,
  output logic calc_unf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] sum;
  assign sum = dec ? {1'b0, base_ea} - {1'b0, step} : {1'b0, base_ea} + {1'b0, step};
  // Raw result, bit 15 left as the adder gives it
  assign calc_ea = sum[15:0];
  assign calc_ovf = !dec && sum[16];
  assign calc_unf = dec && base_ea[15] && !sum[15];
endmodule // pds_agu_model
`default_nettype wire

// ---- tb/pds_paging_chk.sv ----
`default_nettype none
module pds_paging_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rd_page_load,
  input wire logic wr_page_load,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_mode,
  input wire logic [15:0] base_ea,
  input wire logic calc_ovf,
  input wire logic out_valid,
  input wire logic [15:0] effective_address,
  input wire logic [9:0] out_page,
  input wire logic [24:0] out_ext_addr,
  input wire logic addr_err_trap,
  input wire logic [9:0] read_page_reg,
  input wire logic [9:0] write_page_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_rd_ovf;
    acc_valid && !acc_write && base_ea[15] && calc_ovf && !rd_page_load;
  endsequence
  sequence s_prepost;
    acc_mode == 3'h1 || acc_mode == 3'h2;
  endsequence
  property p_resp;
    acc_valid |=> out_valid;
  endproperty
  a_resp: assert property (p_resp) else $error("no answer");
  property p_idle;
    !acc_valid |=> !out_valid && !addr_err_trap;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_ovf;
    s_rd_ovf ##0 s_prepost ##0 read_page_reg < 10'h1FF
      |=> read_page_reg == $past(read_page_reg) + 10'h001 && effective_address[15];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow step");
  property p_wrap;
    s_rd_ovf ##0 acc_mode >= 3'h3 && acc_mode <= 3'h5
      |=> $stable(read_page_reg) && effective_address[15];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap step");
  property p_edge;
    s_rd_ovf ##0 s_prepost ##0 read_page_reg == 10'h1FF
      |=> read_page_reg == 10'h1FF && !effective_address[15];
  endproperty
  a_edge: assert property (p_edge) else $error("last page");
  property p_rdonly;
    acc_valid && !acc_write && !wr_page_load |=> $stable(write_page_reg);
  endproperty
  a_rdonly: assert property (p_rdonly) else $error("write page moved");
  property p_ext;
    out_valid |-> out_ext_addr == {out_page, effective_address[14:0]}
      && (effective_address[15] || out_page == 10'h000);
  endproperty
  a_ext: assert property (p_ext) else $error("ext address");
  property p_trap;
    acc_valid && acc_write && base_ea[15] && write_page_reg[9] |=> addr_err_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("no trap");
endmodule // pds_paging_chk
bind pds_paging pds_paging_chk u_chk (.ref_clk, .rst, .rd_page_load, .wr_page_load,
  .acc_valid, .acc_write, .acc_mode, .base_ea, .calc_ovf, .out_valid, .effective_address,
  .out_page, .out_ext_addr, .addr_err_trap, .read_page_reg, .write_page_reg);
`default_nettype wire

// ---- tb/tb_pds_paging.sv ----
`default_nettype none
module tb_pds_paging;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_page_load = 1'b0;
  logic wr_page_load = 1'b0;
  logic [9:0] page_load_data = 10'h000;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic [2:0] acc_mode = 3'h0;
  logic [15:0] base_ea = 16'h0000;
  logic [15:0] step = 16'h0000;
  logic dec = 1'b0;
  logic [15:0] calc_ea, effective_address;
  logic calc_ovf, calc_unf, out_valid, out_prog_space, addr_err_trap;
  logic [9:0] out_page, read_page_reg, write_page_reg;
  logic [24:0] out_ext_addr;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  pds_agu_model agu (.base_ea, .step, .dec, .calc_ea, .calc_ovf, .calc_unf);
  pds_paging dut (.ref_clk, .rst, .rd_page_load, .wr_page_load, .page_load_data, .acc_valid,
    .acc_write, .acc_mode, .base_ea, .calc_ea, .calc_ovf, .calc_unf, .out_valid,
    .effective_address, .out_page, .out_ext_addr, .out_prog_space, .addr_err_trap,
    .read_page_reg, .write_page_reg);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(string n, logic [24:0] s, logic [24:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic ld(logic rd, logic [9:0] v);
    @(posedge ref_clk);
    rd_page_load <= rd;
    wr_page_load <= !rd;
    page_load_data <= v;
    @(posedge ref_clk);
    rd_page_load <= 1'b0;
    wr_page_load <= 1'b0;
  endtask
  task automatic acc(logic w, logic [2:0] m, logic [15:0] b, logic [15:0] s, logic d,
    logic [15:0] ea, logic [9:0] pg, logic trap);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_mode <= m;
    base_ea <= b;
    step <= s;
    dec <= d;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    #1;
    chk("valid", out_valid, 1'b1);
    chk("ea", effective_address, ea);
    chk("page", out_page, pg);
    chk("trap", addr_err_trap, trap);
  endtask
  task automatic t_reset();
    #1;
    chk("rd_reset", read_page_reg, 10'h001);
    chk("wr_reset", write_page_reg, 10'h001);
  endtask
  task automatic t_linear();
    ld(1'b1, 10'h002);
    acc(1'b0, 3'h1, 16'hFFFE, 16'h0002, 1'b0, 16'h8000, 10'h003, 1'b0);
    chk("ext", out_ext_addr, 25'h01_8000);
    chk("wr_kept", write_page_reg, 10'h001);
    acc(1'b0, 3'h2, 16'h8000, 16'h0002, 1'b1, 16'hFFFE, 10'h002, 1'b0);
  endtask
  task automatic t_edges();
    ld(1'b1, 10'h1FF);
    acc(1'b0, 3'h1, 16'hFFFE, 16'h0002, 1'b0, 16'h0000, 10'h000, 1'b0);
    chk("rd_1ff", read_page_reg, 10'h1FF);
    ld(1'b1, 10'h300);
    acc(1'b0, 3'h1, 16'h8000, 16'h0002, 1'b1, 16'hFFFE, 10'h2FF, 1'b0);
    chk("rd_2ff", read_page_reg, 10'h2FF);
    ld(1'b1, 10'h200);
    acc(1'b0, 3'h2, 16'h8000, 16'h0002, 1'b1, 16'h7FFE, 10'h000, 1'b0);
    chk("rd_200", read_page_reg, 10'h200);
    ld(1'b1, 10'h2FF);
    acc(1'b0, 3'h1, 16'hFFFE, 16'h0002, 1'b0, 16'h8000, 10'h300, 1'b0);
    chk("psv_rd", out_prog_space, 1'b1);
    acc(1'b1, 3'h0, 16'h8000, 16'h0000, 1'b0, 16'h8000, 10'h001, 1'b0);
    chk("psv_wr", out_prog_space, 1'b0);
    chk("rd_300", read_page_reg, 10'h300);
  endtask
  task automatic t_wrap();
    ld(1'b1, 10'h005);
    acc(1'b0, 3'h4, 16'hFFFE, 16'h0002, 1'b0, 16'h8000, 10'h005, 1'b0);
    chk("rd_wrap", read_page_reg, 10'h005);
    acc(1'b0, 3'h5, 16'h8000, 16'h0002, 1'b1, 16'hFFFE, 10'h005, 1'b0);
    acc(1'b1, 3'h3, 16'hFFFE, 16'h0002, 1'b0, 16'h8000, 10'h001, 1'b0);
    chk("wr_wrap", write_page_reg, 10'h001);
  endtask
  task automatic t_write();
    ld(1'b0, 10'h200);
    acc(1'b1, 3'h0, 16'h8000, 16'h0000, 1'b0, 16'h8000, 10'h200, 1'b1);
    ld(1'b0, 10'h000);
    #1;
    chk("wr_zero", write_page_reg, 10'h200);
    ld(1'b0, 10'h1FF);
    acc(1'b1, 3'h1, 16'hFFFE, 16'h0002, 1'b0, 16'h0000, 10'h000, 1'b0);
    chk("wr_1ff", write_page_reg, 10'h1FF);
    ld(1'b0, 10'h007);
    acc(1'b1, 3'h0, 16'h8000, 16'h0000, 1'b0, 16'h8000, 10'h007, 1'b0);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_linear();
    t_edges();
    t_wrap();
    t_write();
    stop_test();
  end
endmodule // tb_pds_paging
`default_nettype wire
